/* File: include/pwp_pkg.sv */
`default_nettype none
package pwp_pkg;

  // ==========================================================
  // widths
  localparam int unsigned PWP_AW = 4;
  localparam int unsigned PWP_DW = 8;
  localparam int unsigned PWP_TW = 10;

  // ==========================================================
  // register offsets (word index on the plain register port)
  localparam logic [3:0] PWP_OFS_PULLUP   = 4'h0;
  localparam logic [3:0] PWP_OFS_WDT_CTRL = 4'h1;
  localparam logic [3:0] PWP_OFS_IRQ_MASK = 4'h2;
  localparam logic [3:0] PWP_OFS_PRD1_LO  = 4'h3;
  localparam logic [3:0] PWP_OFS_PRD2_LO  = 4'h4;
  localparam logic [3:0] PWP_OFS_PRD_HI   = 4'h5;
  localparam logic [3:0] PWP_OFS_DUTY1_LO = 4'h6;
  localparam logic [3:0] PWP_OFS_DUTY2_LO = 4'h7;
  localparam logic [3:0] PWP_OFS_DUTY_HI  = 4'h8;
  localparam logic [3:0] PWP_OFS_FLAGS    = 4'h9;
  localparam logic [3:0] PWP_OFS_PWM_CTRL = 4'hA;
  localparam logic [3:0] PWP_OFS_CH1_COUNTER_LO  = 4'hB;
  localparam logic [3:0] PWP_OFS_TMR2_LO  = 4'hC;
  localparam logic [3:0] PWP_OFS_TMR_HI   = 4'hD;
  localparam logic [3:0] PWP_OFS_STATUS   = 4'hE;

  // ==========================================================
  // watchdog control fields
  localparam int unsigned PWP_WDT_ON_BIT    = 7;
  localparam int unsigned PWP_EXT_SEL_BIT   = 6;
  localparam int unsigned PWP_WDT_DIV_BIT   = 5;
  localparam int unsigned PWP_WDT_RATIO_MSB = 4;
  localparam int unsigned PWP_WDT_RATIO_LSB = 2;

  // interrupt mask / flag bit positions
  localparam int unsigned PWP_IRQ_CMP  = 7;
  localparam int unsigned PWP_IRQ_PWM3 = 6;
  localparam int unsigned PWP_IRQ_PWM2 = 5;
  localparam int unsigned PWP_IRQ_PWM1 = 4;
  localparam int unsigned PWP_IRQ_ADC  = 3;
  localparam int unsigned PWP_IRQ_EXT  = 2;
  localparam int unsigned PWP_IRQ_IC   = 1;
  localparam int unsigned PWP_IRQ_TC   = 0;

  // bits of the flag register held locally (others come from outside)
  localparam logic [7:0] PWP_LOCAL_FLAGS = 8'h34;

  // pwm control fields
  localparam int unsigned PWP_PWM1_EN_BIT = 0;
  localparam int unsigned PWP_PWM2_EN_BIT = 1;

  // ==========================================================
  // reset values
  localparam logic [7:0] PWP_RST_PULLUP = 8'hFF;
  localparam logic [5:0] PWP_RST_WDT    = 6'h00;
  localparam logic [7:0] PWP_RST_MASK   = 8'h00;
  localparam logic [9:0] PWP_RST_PERIOD = 10'h0FF;
  localparam logic [9:0] PWP_RST_DUTY   = 10'h080;
  localparam logic [1:0] PWP_RST_PWMEN  = 2'h0;
  localparam logic [7:0] PWP_RST_FLAGS  = 8'h00;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pwp_bus_req_t;

  typedef struct packed {
    logic [9:0] period;
    logic [9:0] duty;
  } pwp_pwm_cfg_t;

endpackage
`default_nettype wire

/* File: rtl/pwp_pwm_chan.sv */
`default_nettype none
module pwp_pwm_chan
  import pwp_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         rstn,
  input  wire logic         enable,
  input  wire logic         tick,
  input  wire pwp_pwm_cfg_t cfg,
  output logic [9:0]        timer,
  output logic              pwm_out,
  output logic              period_hit
);

  // ==========================================================
  // channel timer
  logic [9:0] timer_reg;
  logic [9:0] timer_next;
  logic       out_reg;
  logic       out_next;
  logic       hit_reg;
  logic       hit_next;

  always_comb begin
    timer_next = timer_reg;
    out_next   = out_reg;
    hit_next   = 1'b0;
    if (!enable) begin
      // idle channel parks at the start of a period
      timer_next = 10'h000;
      out_next   = 1'b0;
    end else if (tick) begin
      if (timer_reg == cfg.period) begin
        timer_next = 10'h000;                    // [RULE17] [RULE19]
        out_next   = 1'b1;                       // [RULE19]
        hit_next   = 1'b1;                       // [RULE19]
      end else begin
        timer_next = timer_reg + 10'h001;
        if (timer_reg == 10'h000) begin
          out_next = 1'b1;                       // [RULE18]
        end
        if (timer_next == cfg.duty) begin
          out_next = 1'b0;                       // [RULE18]
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      timer_reg <= 10'h000;
      out_reg   <= 1'b0;
      hit_reg   <= 1'b0;
    end else begin
      timer_reg <= timer_next;
      out_reg   <= out_next;
      hit_reg   <= hit_next;
    end
  end

  assign timer      = timer_reg;
  assign pwm_out    = out_reg;
  assign period_hit = hit_reg;

endmodule
`default_nettype wire

/* File: rtl/pwp_regs.sv */
// The strobed register port and the register offsets were left to the implementer.
`default_nettype none
// Function
// [RULE1] pull-up bit 0 means pull-up on
// [RULE2] bits 7..4 port6, bits 3..0 port5
// [RULE3] watchdog control bit 7 enables watchdog
// [RULE4] bit 6 selects external interrupt pin
// [RULE5] unselected pin interrupt blocked, level readable
// [RULE6] bit 5 off gives watchdog 1:1 rate
// [RULE7] ratio code n divides by 2^(n+1)
// [RULE8] watchdog control bits 1,0 read zero
// [RULE9] source interrupts only while mask bit set
// [RULE10] global enable by instructions, above masks
// [RULE11] mask bit order cmp down to timer
// [RULE12] software sets comparator mask to use change
// [RULE13] software sets adc mask to use completion
// [RULE14] software sets input-change mask to use change
// [RULE15] pwm1 period 10 bits, high in bank
// [RULE16] pwm2 period 10 bits, high in bank
// [RULE17] period sets the channel time base
// [RULE18] output high until timer equals duty
// [RULE19] at period: restart, go high, raise flag
module pwp_regs
  import pwp_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         rstn,
  input  wire pwp_bus_req_t bus_req,
  output logic [7:0]        bus_rdata,
  input  wire logic         global_irq_enable_instr,
  input  wire logic         global_irq_disable_instr,
  input  wire logic [7:0]   ext_irq_flags,
  input  wire logic         ext_int_n_pin,
  input  wire logic         wdt_osc_tick,
  input  wire logic         pwm_tick,
  output logic [3:0]        port6_pullup_on,
  output logic [3:0]        port5_pullup_on,
  output logic              watchdog_on,
  output logic              wdt_count_tick,
  output logic              ext_irq_pin_select,
  output logic              p50_level,
  output logic              irq_request,
  output logic              wake_request,
  output logic              pwm_ch1_out,
  output logic              pwm_ch2_out
);

  // ==========================================================
  // register state
  logic [7:0] pullup_disable_bits_reg;
  logic [7:0] pullup_disable_bits_next;
  logic [5:0] watchdog_control_reg;
  logic [5:0] watchdog_control_next;
  logic [7:0] interrupt_enable_mask_reg;
  logic [7:0] interrupt_enable_mask_next;
  logic [9:0] pwm1_period_reg;
  logic [9:0] pwm1_period_next;
  logic [9:0] pwm2_period_reg;
  logic [9:0] pwm2_period_next;
  logic [9:0] pwm1_duty_reg;
  logic [9:0] pwm1_duty_next;
  logic [9:0] pwm2_duty_reg;
  logic [9:0] pwm2_duty_next;
  logic [1:0] pwm_en_reg;
  logic [1:0] pwm_en_next;
  logic [7:0] local_flags_reg;
  logic [7:0] local_flags_next;
  logic       global_en_reg;
  logic       global_en_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  logic [9:0] ch1_counter;
  logic [9:0] tmr2;
  logic       hit1;
  logic       hit2;
  logic       ext_event;
  logic [7:0] all_flags;
  logic [7:0] wdt_ctrl_view;

  logic wr_hit;
  logic rd_hit;
  assign wr_hit = bus_req.wr;
  assign rd_hit = bus_req.rd;

  // watchdog control reads with the two low bits tied to zero
  assign wdt_ctrl_view = {watchdog_control_reg, 2'b00};   // [RULE8]

  // ==========================================================
  // software register writes
  always_comb begin
    pullup_disable_bits_next   = pullup_disable_bits_reg;
    watchdog_control_next      = watchdog_control_reg;
    interrupt_enable_mask_next = interrupt_enable_mask_reg;
    pwm1_period_next           = pwm1_period_reg;
    pwm2_period_next           = pwm2_period_reg;
    pwm1_duty_next             = pwm1_duty_reg;
    pwm2_duty_next             = pwm2_duty_reg;
    pwm_en_next                = pwm_en_reg;
    if (wr_hit) begin
      unique case (bus_req.addr)
        PWP_OFS_PULLUP:   pullup_disable_bits_next = bus_req.wdata;        // [RULE1]
        PWP_OFS_WDT_CTRL: watchdog_control_next = bus_req.wdata[7:2];      // [RULE3] [RULE8]
        PWP_OFS_IRQ_MASK: interrupt_enable_mask_next = bus_req.wdata;      // [RULE9]
        PWP_OFS_PRD1_LO:  pwm1_period_next[7:0] = bus_req.wdata;           // [RULE15]
        PWP_OFS_PRD2_LO:  pwm2_period_next[7:0] = bus_req.wdata;           // [RULE16]
        PWP_OFS_PRD_HI: begin
          pwm1_period_next[9:8] = bus_req.wdata[1:0];                      // [RULE15]
          pwm2_period_next[9:8] = bus_req.wdata[3:2];                      // [RULE16]
        end
        PWP_OFS_DUTY1_LO: pwm1_duty_next[7:0] = bus_req.wdata;
        PWP_OFS_DUTY2_LO: pwm2_duty_next[7:0] = bus_req.wdata;
        PWP_OFS_DUTY_HI: begin
          pwm1_duty_next[9:8] = bus_req.wdata[1:0];
          pwm2_duty_next[9:8] = bus_req.wdata[3:2];
        end
        PWP_OFS_PWM_CTRL: pwm_en_next = bus_req.wdata[1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      pullup_disable_bits_reg   <= PWP_RST_PULLUP;
      watchdog_control_reg      <= PWP_RST_WDT;
      interrupt_enable_mask_reg <= PWP_RST_MASK;
      pwm1_period_reg           <= PWP_RST_PERIOD;
      pwm2_period_reg           <= PWP_RST_PERIOD;
      pwm1_duty_reg             <= PWP_RST_DUTY;
      pwm2_duty_reg             <= PWP_RST_DUTY;
      pwm_en_reg                <= PWP_RST_PWMEN;
    end else begin
      pullup_disable_bits_reg   <= pullup_disable_bits_next;
      watchdog_control_reg      <= watchdog_control_next;
      interrupt_enable_mask_reg <= interrupt_enable_mask_next;
      pwm1_period_reg           <= pwm1_period_next;
      pwm2_period_reg           <= pwm2_period_next;
      pwm1_duty_reg             <= pwm1_duty_next;
      pwm2_duty_reg             <= pwm2_duty_next;
      pwm_en_reg                <= pwm_en_next;
    end
  end

  // ==========================================================
  // pull-up drive: a stored 0 turns the pull-up on
  // upper nibble serves port 6 pins 7..4, lower nibble port 5 pins 3..0
  assign port6_pullup_on = ~pullup_disable_bits_reg[7:4];   // [RULE1] [RULE2]
  assign port5_pullup_on = ~pullup_disable_bits_reg[3:0];   // [RULE1] [RULE2]

  // ==========================================================
  // watchdog enable and prescaler
  logic [7:0] wdt_div_reg;
  logic [7:0] wdt_div_next;
  logic       wdt_tick_reg;
  logic       wdt_tick_next;
  logic [2:0] wdt_ratio;
  logic       wdt_div_on;
  logic [7:0] wdt_div_mask;

  assign wdt_ratio  = watchdog_control_reg[PWP_WDT_RATIO_MSB-2:PWP_WDT_RATIO_LSB-2];
  assign wdt_div_on = watchdog_control_reg[PWP_WDT_DIV_BIT-2];
  assign watchdog_on = watchdog_control_reg[PWP_WDT_ON_BIT-2];              // [RULE3]

  // low ratio+1 bits all ones marks the end of a 2^(ratio+1) run
  assign wdt_div_mask = 8'((16'h0002 << wdt_ratio) - 16'h0001);           // [RULE7]

  always_comb begin
    wdt_div_next  = wdt_div_reg;
    wdt_tick_next = 1'b0;
    // switching the watchdog off also restarts the divider
    if (!watchdog_on) begin
      wdt_div_next = 8'h00;
    end else if (wdt_osc_tick) begin
      if (!wdt_div_on) begin
        wdt_tick_next = 1'b1;                                              // [RULE6]
      end else if ((wdt_div_reg & wdt_div_mask) == wdt_div_mask) begin
        wdt_tick_next = 1'b1;                                              // [RULE7]
        wdt_div_next  = 8'h00;
      end else begin
        wdt_div_next = wdt_div_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      wdt_div_reg  <= 8'h00;
      wdt_tick_reg <= 1'b0;
    end else begin
      wdt_div_reg  <= wdt_div_next;
      wdt_tick_reg <= wdt_tick_next;
    end
  end

  // registered so the watchdog counter never sees a combinational glitch
  assign wdt_count_tick = wdt_tick_reg;

  // ==========================================================
  // external interrupt pin: synchronise, then detect falling edge
  logic pin_meta_reg;
  logic pin_sync_reg;
  logic pin_prev_reg;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      pin_meta_reg <= 1'b1;
      pin_sync_reg <= 1'b1;
      pin_prev_reg <= 1'b1;
    end else begin
      pin_meta_reg <= ext_int_n_pin;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  assign ext_irq_pin_select = watchdog_control_reg[PWP_EXT_SEL_BIT-2];      // [RULE4]
  // masked path when deselected; the level stays visible for port reads
  assign ext_event = ext_irq_pin_select & pin_prev_reg & ~pin_sync_reg;     // [RULE5]
  assign p50_level = pin_sync_reg;                                          // [RULE5]

  // ==========================================================
  // pwm channels: one identical timer per channel, indexed by its enable bit
  pwp_pwm_cfg_t chan_cfg   [2];
  logic [9:0]   chan_timer [2];
  logic         chan_out   [2];
  logic         chan_hit   [2];

  assign chan_cfg[PWP_PWM1_EN_BIT] = '{period: pwm1_period_reg, duty: pwm1_duty_reg};
  assign chan_cfg[PWP_PWM2_EN_BIT] = '{period: pwm2_period_reg, duty: pwm2_duty_reg};

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    pwp_pwm_chan u_pwm_chan (
      .clock      (clock),
      .rstn       (rstn),
      .enable     (pwm_en_reg[ch]),
      .tick       (pwm_tick),
      .cfg        (chan_cfg[ch]),
      .timer      (chan_timer[ch]),
      .pwm_out    (chan_out[ch]),
      .period_hit (chan_hit[ch])
    );
  end

  assign ch1_counter        = chan_timer[PWP_PWM1_EN_BIT];
  assign tmr2        = chan_timer[PWP_PWM2_EN_BIT];
  assign hit1        = chan_hit[PWP_PWM1_EN_BIT];
  assign hit2        = chan_hit[PWP_PWM2_EN_BIT];
  assign pwm_ch1_out = chan_out[PWP_PWM1_EN_BIT];
  assign pwm_ch2_out = chan_out[PWP_PWM2_EN_BIT];

  // ==========================================================
  // locally raised flags: write 1 clears, a new event wins over the clear
  logic [7:0] flag_set;
  logic [7:0] flag_clr;

  always_comb begin
    flag_set = 8'h00;
    flag_set[PWP_IRQ_PWM1] = hit1;                                          // [RULE19]
    flag_set[PWP_IRQ_PWM2] = hit2;                                          // [RULE19]
    flag_set[PWP_IRQ_EXT]  = ext_event;
    flag_clr = 8'h00;
    if (wr_hit && bus_req.addr == PWP_OFS_FLAGS) begin
      flag_clr = bus_req.wdata & PWP_LOCAL_FLAGS;
    end
    local_flags_next = ((local_flags_reg & ~flag_clr) | flag_set) & PWP_LOCAL_FLAGS;
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      local_flags_reg <= PWP_RST_FLAGS;
    end else begin
      local_flags_reg <= local_flags_next;
    end
  end

  // flags owned outside pass straight through and are never stored here
  assign all_flags = local_flags_reg | (ext_irq_flags & ~PWP_LOCAL_FLAGS);  // [RULE11]

  // ==========================================================
  // global enable and interrupt request
  always_comb begin
    global_en_next = global_en_reg;
    if (global_irq_enable_instr) begin
      global_en_next = 1'b1;                                                // [RULE10]
    end else if (global_irq_disable_instr) begin
      global_en_next = 1'b0;                                                // [RULE10]
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      global_en_reg <= 1'b0;
    end else begin
      global_en_reg <= global_en_next;
    end
  end

  // wake ignores the global enable so a masked-in event resumes at the
  // next instruction when interrupts are off
  assign wake_request = |(all_flags & interrupt_enable_mask_reg);          // [RULE9]
  assign irq_request  = global_en_reg & wake_request;                       // [RULE10]

  // ==========================================================
  // read port: data valid only in the cycle after the strobe
  // reads have no side effects, so flags clear only on a write
  always_comb begin
    rdata_next = 8'h00;
    if (rd_hit) begin
      unique case (bus_req.addr)
        PWP_OFS_PULLUP:   rdata_next = pullup_disable_bits_reg;
        PWP_OFS_WDT_CTRL: rdata_next = wdt_ctrl_view;                       // [RULE8]
        PWP_OFS_IRQ_MASK: rdata_next = interrupt_enable_mask_reg;
        PWP_OFS_PRD1_LO:  rdata_next = pwm1_period_reg[7:0];
        PWP_OFS_PRD2_LO:  rdata_next = pwm2_period_reg[7:0];
        PWP_OFS_PRD_HI:   rdata_next = {4'h0, pwm2_period_reg[9:8], pwm1_period_reg[9:8]};
        PWP_OFS_DUTY1_LO: rdata_next = pwm1_duty_reg[7:0];
        PWP_OFS_DUTY2_LO: rdata_next = pwm2_duty_reg[7:0];
        PWP_OFS_DUTY_HI:  rdata_next = {4'h0, pwm2_duty_reg[9:8], pwm1_duty_reg[9:8]};
        PWP_OFS_FLAGS:    rdata_next = all_flags;
        PWP_OFS_PWM_CTRL: rdata_next = {6'h00, pwm_en_reg};
        PWP_OFS_CH1_COUNTER_LO:  rdata_next = ch1_counter[7:0];
        PWP_OFS_TMR2_LO:  rdata_next = tmr2[7:0];
        PWP_OFS_TMR_HI:   rdata_next = {4'h0, tmr2[9:8], ch1_counter[9:8]};
        PWP_OFS_STATUS:   rdata_next = {6'h00, global_en_reg, p50_level};
        default:          rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign bus_rdata = rdata_reg;

endmodule
`default_nettype wire

/* File: sim/pwp_regs_asserts.sv */
`default_nettype none
module pwp_regs_chk
  import pwp_pkg::*;
(
  input wire logic         clock,
  input wire logic         rstn,
  input wire pwp_bus_req_t bus_req,
  input wire logic [7:0]   bus_rdata,
  input wire logic         global_irq_enable_instr,
  input wire logic         global_irq_disable_instr,
  input wire logic         wdt_osc_tick,
  input wire logic [3:0]   port6_pullup_on,
  input wire logic [3:0]   port5_pullup_on,
  input wire logic         watchdog_on,
  input wire logic         wdt_count_tick,
  input wire logic         ext_irq_pin_select,
  input wire logic         irq_request,
  input wire logic         wake_request
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  // ==========================================================
  // shadow copies rebuilt from the bus, so no internal probe is needed
  wire logic [7:0] wd   = bus_req.wdata;
  wire logic       w_pu = bus_req.wr && (bus_req.addr == PWP_OFS_PULLUP);
  wire logic       w_wd = bus_req.wr && (bus_req.addr == PWP_OFS_WDT_CTRL);
  wire logic       w_mk = bus_req.wr && (bus_req.addr == PWP_OFS_IRQ_MASK);
  wire logic       r_wd = bus_req.rd && (bus_req.addr == PWP_OFS_WDT_CTRL);
  wire logic       r_mk = bus_req.rd && (bus_req.addr == PWP_OFS_IRQ_MASK);
  logic [7:0]      wdt_reg, wdt_next, mask_reg, mask_next;

  always_comb begin
    wdt_next  = w_wd ? wd : wdt_reg;
    mask_next = w_mk ? wd : mask_reg;
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      wdt_reg  <= 8'h00;
      mask_reg <= 8'h00;
    end else begin
      wdt_reg  <= wdt_next;
      mask_reg <= mask_next;
    end
  end

  // ==========================================================
  // properties
  property p_pu5;
    w_pu |=> port5_pullup_on == ~$past(wd[3:0]);
  endproperty
  a_pu5: assert property (p_pu5) else $error("port5 pull-up wrong");
  property p_pu6;
    w_pu |=> port6_pullup_on == ~$past(wd[7:4]);
  endproperty
  a_pu6: assert property (p_pu6) else $error("port6 pull-up wrong");
  property p_wdon;
    w_wd |=> watchdog_on == $past(wd[7]);
  endproperty
  a_wdon: assert property (p_wdon) else $error("watchdog enable wrong");
  property p_sel;
    w_wd |=> ext_irq_pin_select == $past(wd[6]);
  endproperty
  a_sel: assert property (p_sel) else $error("pin select wrong");
  property p_rd01;
    r_wd |=> bus_rdata[1:0] == 2'h0;
  endproperty
  a_rd01: assert property (p_rd01) else $error("low bits not zero");
  property p_div1;
    wdt_reg[7] && !wdt_reg[5] |=> wdt_count_tick == $past(wdt_osc_tick);
  endproperty
  a_div1: assert property (p_div1) else $error("undivided tick wrong");
  property p_mask0;
    mask_reg == 8'h00 |-> !wake_request && !irq_request;
  endproperty
  a_mask0: assert property (p_mask0) else $error("masked source active");
  property p_mkrd;
    r_mk |=> bus_rdata == $past(mask_reg);
  endproperty
  a_mkrd: assert property (p_mkrd) else $error("mask readback wrong");
  property p_global_irq_disable_instr;
    global_irq_disable_instr && !global_irq_enable_instr |=> !irq_request;
  endproperty
  a_global_irq_disable_instr: assert property (p_global_irq_disable_instr) else $error("request after disable");
  property p_eni;
    global_irq_enable_instr |=> irq_request == wake_request;
  endproperty
  a_eni: assert property (p_eni) else $error("request after enable wrong");
endmodule

bind pwp_regs pwp_regs_chk u_pwp_regs_chk (
  .clock, .rstn, .bus_req, .bus_rdata, .global_irq_enable_instr,
  .global_irq_disable_instr, .wdt_osc_tick, .port6_pullup_on, .port5_pullup_on,
  .watchdog_on, .wdt_count_tick, .ext_irq_pin_select, .irq_request, .wake_request
);
`default_nettype wire

/* File: sim/testbench.sv */
`default_nettype none
module testbench
  import pwp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clock = 1'h0, rstn = 1'h0;
  pwp_bus_req_t bus_req = '0;
  logic [7:0]   bus_rdata, ext_irq_flags = 8'h00;
  logic         global_irq_enable_instr = 1'h0, global_irq_disable_instr = 1'h0;
  logic         ext_int_n_pin = 1'h1, wdt_osc_tick = 1'h0, pwm_tick = 1'h1;
  logic [3:0]   port6_pullup_on, port5_pullup_on;
  logic         watchdog_on, wdt_count_tick, ext_irq_pin_select, p50_level;
  logic         irq_request, wake_request, pwm_ch1_out, pwm_ch2_out;
  int           n_errors = 0, checks = 0, cyc = 0, nwt = 0;

  pwp_regs u_pwp_regs (.clock, .rstn, .bus_req, .bus_rdata, .global_irq_enable_instr,
    .global_irq_disable_instr, .ext_irq_flags, .ext_int_n_pin, .wdt_osc_tick, .pwm_tick,
    .port6_pullup_on, .port5_pullup_on, .watchdog_on, .wdt_count_tick, .ext_irq_pin_select,
    .p50_level, .irq_request, .wake_request, .pwm_ch1_out, .pwm_ch2_out);

  always #5 clock = ~clock;

  // ==========================================================
  // cycle ceiling well above the roughly 3000 cycles the run needs
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (wdt_count_tick) nwt <= nwt + 1;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  // ==========================================================
  // helpers
  task automatic print_verdict();
    $display("errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    @(posedge clock);
    bus_req.wr <= 1'h0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
    @(posedge clock);
    bus_req.rd <= 1'h0;
    #1 check(10'(bus_rdata), 10'(e));
  endtask
  task automatic meas(input logic ch, input logic [9:0] per, input logic [9:0] hi);
    logic [9:0] np, nh;
    np = 10'h000;
    nh = 10'h000;
    // the first high run after enabling is short, so lock on a later period start
    repeat (2) begin
      do @(posedge clock); while ((ch ? pwm_ch1_out : pwm_ch2_out) !== 1'h0);
      do @(posedge clock); while ((ch ? pwm_ch1_out : pwm_ch2_out) !== 1'h1);
    end
    do begin
      np++;
      nh += 10'(ch ? pwm_ch1_out : pwm_ch2_out);
      @(posedge clock);
    end while ((ch ? pwm_ch1_out : pwm_ch2_out) !== 1'h1 || np < 2);
    check(np, per);
    check(nh, hi);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    rchk(PWP_OFS_PULLUP, 8'hFF);
    check(10'(port5_pullup_on), 10'h000);
    check(10'(port6_pullup_on), 10'h000);
    rchk(PWP_OFS_WDT_CTRL, 8'h00);
    rchk(PWP_OFS_IRQ_MASK, 8'h00);
    rchk(PWP_OFS_PRD1_LO, 8'hFF);
    rchk(PWP_OFS_PRD_HI, 8'h00);
    wr(4'hF, 8'hAA);
    rchk(4'hF, 8'h00);
  endtask
  task automatic t_pullup();
    wr(PWP_OFS_PULLUP, 8'h5A);
    #1 check(10'(port6_pullup_on), 10'h00A);
    check(10'(port5_pullup_on), 10'h005);
    rchk(PWP_OFS_PULLUP, 8'h5A);
  endtask
  task automatic t_wdt();
    wr(PWP_OFS_WDT_CTRL, 8'hFF);
    #1 check(10'(watchdog_on), 10'h001);
    check(10'(ext_irq_pin_select), 10'h001);
    rchk(PWP_OFS_WDT_CTRL, 8'hFC);
    wr(PWP_OFS_WDT_CTRL, 8'h00);
    #1 check(10'(watchdog_on), 10'h000);
  endtask
  task automatic t_ratio();
    int n;
    for (int c = -1; c < 8; c++) begin
      wr(PWP_OFS_WDT_CTRL, 8'h00);
      wr(PWP_OFS_WDT_CTRL, (c < 0) ? 8'h80 : (8'hA0 | 8'(c << 2)));
      #1 nwt = 0;
      n = (c < 0) ? 5 : (2 << (c + 1));
      repeat (n) begin
        @(posedge clock);
        wdt_osc_tick <= 1'h1;
      end
      @(posedge clock);
      wdt_osc_tick <= 1'h0;
      repeat (2) @(posedge clock);
      #1 check(10'(nwt), (c < 0) ? 10'h005 : 10'h002);
    end
  endtask
  task automatic t_mask();
    int         b[5] = '{7, 6, 3, 1, 0};
    logic [1:0] pat[4] = '{2'h2, 2'h1, 2'h3, 2'h1};
    logic [3:0] ex = 4'h5;
    foreach (b[i]) begin
      wr(PWP_OFS_IRQ_MASK, 8'h01 << b[i]);
      ext_irq_flags <= ~(8'h01 << b[i]);
      repeat (3) @(posedge clock);
      #1 check(10'(wake_request), 10'h000);
      @(posedge clock);
      ext_irq_flags <= 8'h01 << b[i];
      repeat (3) @(posedge clock);
      #1 check(10'(wake_request), 10'h001);
      check(10'(irq_request), 10'h000);
    end
    for (int k = 0; k < 4; k++) begin
      @(posedge clock);
      {global_irq_enable_instr, global_irq_disable_instr} <= pat[k];
      @(posedge clock);
      {global_irq_enable_instr, global_irq_disable_instr} <= 2'h0;
      #1 check(10'(irq_request), 10'(ex[k]));
    end
    ext_irq_flags <= 8'h00;
  endtask
  task automatic t_ext();
    wr(PWP_OFS_IRQ_MASK, 8'h04);
    wr(PWP_OFS_WDT_CTRL, 8'h00);
    ext_int_n_pin <= 1'h0;
    repeat (6) @(posedge clock);
    #1 check(10'(wake_request), 10'h000);
    @(posedge clock);
    ext_int_n_pin <= 1'h1;
    wr(PWP_OFS_WDT_CTRL, 8'h40);
    ext_int_n_pin <= 1'h0;
    repeat (5) @(posedge clock);
    #1 check(10'(wake_request), 10'h001);
    check(10'(p50_level), 10'h000);
    rchk(PWP_OFS_STATUS, 8'h00);
    wr(PWP_OFS_FLAGS, 8'h04);
    #1 check(10'(wake_request), 10'h000);
  endtask
  task automatic t_pwm();
    wr(PWP_OFS_PRD1_LO, 8'h05);
    wr(PWP_OFS_PRD2_LO, 8'h03);
    wr(PWP_OFS_PRD_HI, 8'h00);
    wr(PWP_OFS_DUTY1_LO, 8'h02);
    wr(PWP_OFS_DUTY2_LO, 8'h01);
    wr(PWP_OFS_DUTY_HI, 8'h00);
    wr(PWP_OFS_IRQ_MASK, 8'h10);
    wr(PWP_OFS_PWM_CTRL, 8'h03);
    meas(1'h1, 10'h006, 10'h002);
    meas(1'h0, 10'h004, 10'h001);
    #1 check(10'(wake_request), 10'h001);
    rchk(PWP_OFS_FLAGS, 8'h30);
    wr(PWP_OFS_PRD_HI, 8'h05);
    rchk(PWP_OFS_PRD1_LO, 8'h05);
    meas(1'h1, 10'h106, 10'h002);
    meas(1'h0, 10'h104, 10'h001);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge clock);
    rstn <= 1'h1;
    t_reset();
    t_pullup();
    t_wdt();
    t_ratio();
    t_mask();
    t_ext();
    t_pwm();
    print_verdict();
  end
endmodule
`default_nettype wire
